// ---- core/acu_pkg.sv ----
// Purpose: shared constants for the adaptive clock unit
// Assumes: 32-bit APB, one aligned word per byte register
// Notes: offsets are byte addresses
package acu_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FREQ_WORD_HIGH = 8'h00;
    localparam logic [7:0] OFF_FREQ_WORD_MID = 8'h04;
    localparam logic [7:0] OFF_FREQ_WORD_LOW_COMMIT = 8'h08;
    localparam logic [7:0] OFF_CAPTURE_VALUE_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CAPTURE_VALUE_LOW = 8'h10;
    localparam logic [7:0] OFF_DIVIDER_CONTROL = 8'h14;
    localparam logic [7:0] OFF_CLOCK_GEN_CONTROL = 8'h18;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int DIV_SEL_LSB = 0;
    localparam int DIV_SEL_W = 4;
    localparam int CTL_CAPTURE_SELECT_BIT = 0;
    localparam int CTL_EXT_CLOCK_SELECT_BIT = 1;
    localparam int FREQ_W = 24;
    localparam int FREQ_FRAC_W = 18;
    localparam int CAPTURE_W = 16;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [23:0] FREQ_RESET = 24'h600000;
    localparam logic [3:0] DIV_SEL_RESET = 4'h0;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [23:0] FREQ_MIN = 24'h600000;
    localparam logic [23:0] FREQ_MAX = 24'hc80000;
    // synthesizer step per system clock, same units as the frequency word
    localparam logic [23:0] SYNTH_STEP = 24'h600000;

endpackage

// ---- core/acu_duty_divider.sv ----
// Purpose: divide a half-period tick stream by 1 to 16, 50% duty
// Assumes: tick marks one half period of the synthesizer clock
// Notes: restart clears count and output low
`timescale 1ns/1ps
module acu_duty_divider #(
    parameter int SEL_W = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic restart,
    input wire logic [SEL_W-1:0] ratioSel,
    output logic clkOut
);

    typedef struct packed {
        logic [SEL_W-1:0] count;
        logic level;
    } acu_div_s;

    acu_div_s state;
    acu_div_s next_state;

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    // counting half periods keeps odd ratios symmetric
    always_comb begin
        next_state = state;
        if (restart) begin
            next_state.count = '0;
            next_state.level = 1'b0;
        end else if (tick) begin
            if (state.count >= ratioSel) begin
                next_state.count = '0;
                next_state.level = ~state.level;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clkOut = state.level;

endmodule

// ---- core/acu_clock_gen.sv ----
// Purpose: adaptive codec clock generator with frame capture
// Assumes: all inputs synchronous to clk; APB slave with one wait state
// Notes: the synthesizer is a fractional accumulator at clk rate
//
// Notes on behaviour
// - the synthesizer clock passes a divider set from 1 to 16 to make the master clock.
// - the master clock has 50% duty for every divide setting, odd ones included.
// - the frequency word may be rewritten at any time while the generator runs.
// - high and mid bytes are staged; the whole word loads on the low byte write.
// - the word is fixed point, 6 integer bits and 18 fraction bits.
// - the divisor is valid from 24 to 50 and the output rate scales as 24 over it.
// - a 16-bit counter runs freely on each rising edge of the chosen capture clock.
// - a control bit picks the master clock or the secondary clock for the counter.
// - each frame start or pseudo frame start copies the counter into the capture register.
// - the capture register reads as a high byte and a low byte.
// - the codec port clock may come from the external clock input instead.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module acu_clock_gen #(
    parameter int CAP_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic frameStart,
    input wire logic pseudoFrameStart,
    input wire logic secondaryMasterClock,
    input wire logic externalMasterClockIn,
    output logic codecMasterClockOut,
    output logic codecPortClock
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] freqHigh;
        logic [7:0] freqMid;
        logic [23:0] frequencyWord;
        logic [3:0] divSel;
        logic divRestart;
        logic captureClockSelect;
        logic extClockSelect;
        logic [24:0] synthAcc;
        logic synthTick;
        logic captureSrcPrev;
        logic [CAP_W-1:0] captureCount;
        logic [CAP_W-1:0] captureValue;
        logic ready;
        logic [31:0] rdata;
        logic slverr;
        logic portClock;
        logic masterClock;
    } acu_state_s;

    acu_state_s state;
    acu_state_s next_state;

    logic divClock;
    logic [23:0] divisor;
    logic [24:0] accSum;
    logic captureSrc;
    logic accessCycle;
    logic doneCycle;
    logic mapped;
    logic [31:0] readMux;

    // ------------------------------------------------------------
    // divider instance
    // ------------------------------------------------------------
    acu_duty_divider #(
        .SEL_W(acu_pkg::DIV_SEL_W)
    ) u_divider (
        .clk(clk),
        .resetn(resetn),
        .tick(state.synthTick),
        .restart(state.divRestart),
        .ratioSel(state.divSel),
        .clkOut(divClock)
    );

    // ------------------------------------------------------------
    // synthesizer helpers
    // ------------------------------------------------------------
    // out-of-range words are held at the nearest limit rather than
    // letting the accumulator run away
    always_comb begin
        if (state.frequencyWord < acu_pkg::FREQ_MIN) begin
            divisor = acu_pkg::FREQ_MIN;
        end else if (state.frequencyWord > acu_pkg::FREQ_MAX) begin
            divisor = acu_pkg::FREQ_MAX;
        end else begin
            divisor = state.frequencyWord;
        end
    end

    assign accSum = state.synthAcc + {1'b0, acu_pkg::SYNTH_STEP};

    // ------------------------------------------------------------
    // capture source select
    // ------------------------------------------------------------
    always_comb begin
        if (state.captureClockSelect) begin
            captureSrc = secondaryMasterClock;
        end else begin
            captureSrc = state.masterClock;
        end
    end

    // ------------------------------------------------------------
    // bus decode and read mux
    // ------------------------------------------------------------
    assign accessCycle = psel && penable && !state.ready;
    assign doneCycle = psel && penable && state.ready;

    always_comb begin
        mapped = 1'b1;
        readMux = 32'h00000000;
        unique case (paddr)
            acu_pkg::OFF_FREQ_WORD_HIGH: begin
                readMux[7:0] = state.freqHigh;
            end
            acu_pkg::OFF_FREQ_WORD_MID: begin
                readMux[7:0] = state.freqMid;
            end
            acu_pkg::OFF_FREQ_WORD_LOW_COMMIT: begin
                readMux[7:0] = state.frequencyWord[7:0];
            end
            acu_pkg::OFF_CAPTURE_VALUE_HIGH: begin
                readMux[7:0] = state.captureValue[15:8];
            end
            acu_pkg::OFF_CAPTURE_VALUE_LOW: begin
                readMux[7:0] = state.captureValue[7:0];
            end
            acu_pkg::OFF_DIVIDER_CONTROL: begin
                readMux[3:0] = state.divSel;
            end
            acu_pkg::OFF_CLOCK_GEN_CONTROL: begin
                readMux[acu_pkg::CTL_CAPTURE_SELECT_BIT] = state.captureClockSelect;
                readMux[acu_pkg::CTL_EXT_CLOCK_SELECT_BIT] = state.extClockSelect;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.divRestart = 1'b0;
        next_state.ready = 1'b0;

        // fractional accumulator: one tick per half period of the
        // synthesized clock; the word may change mid-run without a stop
        if (accSum >= {1'b0, divisor}) begin
            next_state.synthAcc = accSum - {1'b0, divisor};
            next_state.synthTick = 1'b1;
        end else begin
            next_state.synthAcc = accSum;
            next_state.synthTick = 1'b0;
        end

        // divider output retimed so the pin sees a flop
        next_state.masterClock = divClock;

        // free running counter on rising edges of the chosen source
        next_state.captureSrcPrev = captureSrc;
        if (captureSrc && !state.captureSrcPrev) begin
            next_state.captureCount = state.captureCount + 1'b1;
        end

        // hold value until the next frame event
        if (frameStart || pseudoFrameStart) begin
            next_state.captureValue = state.captureCount;
        end

        // codec port clock source
        if (state.extClockSelect) begin
            next_state.portClock = externalMasterClockIn;
        end else begin
            next_state.portClock = state.masterClock;
        end

        // first access cycle: latch the answer, raise ready next edge
        if (accessCycle) begin
            next_state.ready = 1'b1;
            next_state.slverr = !mapped;
            if (!pwrite && mapped) begin
                next_state.rdata = readMux;
            end else begin
                next_state.rdata = 32'h00000000;
            end
        end

        // writes take effect on the completing edge only
        if (doneCycle && pwrite && mapped) begin
            unique case (paddr)
                acu_pkg::OFF_FREQ_WORD_HIGH: begin
                    next_state.freqHigh = pwdata[7:0];
                end
                acu_pkg::OFF_FREQ_WORD_MID: begin
                    next_state.freqMid = pwdata[7:0];
                end
                acu_pkg::OFF_FREQ_WORD_LOW_COMMIT: begin
                    next_state.frequencyWord = {state.freqHigh, state.freqMid,
                        pwdata[7:0]};
                end
                acu_pkg::OFF_DIVIDER_CONTROL: begin
                    next_state.divSel = pwdata[acu_pkg::DIV_SEL_LSB +:
                        acu_pkg::DIV_SEL_W];
                    next_state.divRestart = 1'b1;
                end
                acu_pkg::OFF_CLOCK_GEN_CONTROL: begin
                    next_state.captureClockSelect =
                        pwdata[acu_pkg::CTL_CAPTURE_SELECT_BIT];
                    next_state.extClockSelect =
                        pwdata[acu_pkg::CTL_EXT_CLOCK_SELECT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
            state.freqHigh <= acu_pkg::FREQ_RESET[23:16];
            state.freqMid <= acu_pkg::FREQ_RESET[15:8];
            state.frequencyWord <= acu_pkg::FREQ_RESET;
            state.divSel <= acu_pkg::DIV_SEL_RESET;
            state.captureCount <= acu_pkg::CAPTURE_RESET;
            state.captureValue <= acu_pkg::CAPTURE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready = state.ready;
    assign prdata = state.rdata;
    assign pslverr = state.slverr;
    assign codecMasterClockOut = state.masterClock;
    assign codecPortClock = state.portClock;

endmodule

// ---- tb/acu_clock_gen_chk.sv ----
// Purpose: port checker for the adaptive clock unit
// Assumes: one clock domain, async active-low reset
// Notes: shadows the port clock select from apb writes
`timescale 1ns/1ps
module acu_clock_gen_chk #(
    parameter int CAP_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic frameStart,
    input wire logic pseudoFrameStart,
    input wire logic secondaryMasterClock,
    input wire logic externalMasterClockIn,
    input wire logic codecMasterClockOut,
    input wire logic codecPortClock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic extSel;
    logic seenFrame;
    logic mapped;
    logic capRead;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= acu_pkg::OFF_CLOCK_GEN_CONTROL;
    assign capRead = paddr == acu_pkg::OFF_CAPTURE_VALUE_HIGH
        || paddr == acu_pkg::OFF_CAPTURE_VALUE_LOW;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extSel <= 1'b0;
            seenFrame <= 1'b0;
        end else begin
            if (psel && penable && pready && pwrite
                && paddr == acu_pkg::OFF_CLOCK_GEN_CONTROL) begin
                extSel <= pwdata[acu_pkg::CTL_EXT_CLOCK_SELECT_BIT];
            end
            if (frameStart || pseudoFrameStart) begin
                seenFrame <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_firstAccess;
        psel && penable && !pready && !$past(penable);
    endsequence
    property p_oneWait;
        s_firstAccess |=> pready;
    endproperty
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    property p_readyInAccess;
        pready |-> psel && penable && $past(psel && penable);
    endproperty
    property p_errUnmapped;
        pready && !mapped |-> pslverr && prdata == 32'h0;
    endproperty
    property p_okMapped;
        pready && mapped |-> !pslverr;
    endproperty
    property p_upperZero;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    property p_portExt;
        extSel |=> codecPortClock == $past(externalMasterClockIn);
    endproperty
    property p_portInt;
        !extSel |=> codecPortClock == $past(codecMasterClockOut);
    endproperty
    property p_capReset;
        pready && !pwrite && !seenFrame && capRead |-> prdata == 32'h0;
    endproperty
    a_oneWait: assert property (p_oneWait) else $error("no answer after one wait");
    a_readyPulse: assert property (p_readyPulse) else $error("ready held");
    a_readyInAccess: assert property (p_readyInAccess) else $error("ready outside access");
    a_errUnmapped: assert property (p_errUnmapped) else $error("unmapped not refused");
    a_okMapped: assert property (p_okMapped) else $error("mapped refused");
    a_upperZero: assert property (p_upperZero) else $error("byte read has upper bits");
    a_portExt: assert property (p_portExt) else $error("port clock not external");
    a_portInt: assert property (p_portInt) else $error("port clock not master");
    a_capReset: assert property (p_capReset) else $error("capture not clear");
endmodule

bind acu_clock_gen acu_clock_gen_chk #(.CAP_W(CAP_W)) i_acu_clock_gen_chk (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .frameStart(frameStart), .pseudoFrameStart(pseudoFrameStart),
    .secondaryMasterClock(secondaryMasterClock),
    .externalMasterClockIn(externalMasterClockIn),
    .codecMasterClockOut(codecMasterClockOut), .codecPortClock(codecPortClock));

// ---- tb/acu_codec_model.sv ----
// Purpose: codec side clocks for the adaptive clock unit
// Assumes: changes just after rising clk edges
// Notes: secondary clock stands still between bursts so counts are exact
`timescale 1ns/1ps
module acu_codec_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic [7:0] burstLen,
    output logic secondaryMasterClock,
    output logic externalMasterClockIn
);
    logic [8:0] left;
    logic [1:0] phase;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            left <= 9'h0;
            phase <= 2'h0;
            secondaryMasterClock <= 1'b0;
            externalMasterClockIn <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            externalMasterClockIn <= phase[1];
            if (go) begin
                left <= {burstLen, 1'b0};
            end else if (left != 9'h0) begin
                left <= left - 9'h1;
                secondaryMasterClock <= !secondaryMasterClock;
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the adaptive clock unit
// Assumes: one apb request at a time
// Notes: rates checked at integer words only, fractions jitter
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0, burstLen = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic frameStart = 1'b0, pseudoFrameStart = 1'b0, go = 1'b0;
    logic pready, pslverr, secClk, extClk, mclk, portClk;
    int bad_count = 0, total_checks = 0, cycles = 0;
    acu_clock_gen #(.CAP_W(16)) i_acu_clock_gen (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .frameStart(frameStart),
        .pseudoFrameStart(pseudoFrameStart), .secondaryMasterClock(secClk),
        .externalMasterClockIn(extClk), .codecMasterClockOut(mclk),
        .codecPortClock(portClk));
    acu_codec_model i_acu_codec_model (.clk(clk), .resetn(resetn), .go(go),
        .burstLen(burstLen), .secondaryMasterClock(secClk), .externalMasterClockIn(extClk));
    always #50 clk = !clk;
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, e);
        chk(32'(err), 32'h0);
    endtask
    // half periods in clk cycles, taken well after any setting change
    task automatic measure(input int e);
        int hi, lo;
        hi = 0;
        lo = 0;
        repeat (8) @(negedge clk);
        while (mclk !== 1'b0) @(negedge clk);
        while (mclk !== 1'b1) @(negedge clk);
        while (mclk === 1'b1) begin hi++; @(negedge clk); end
        while (mclk === 1'b0) begin lo++; @(negedge clk); end
        chk(hi, e);
        chk(lo, e);
    endtask
    task automatic pulse(input logic pseudo, output int t);
        @(posedge clk);
        frameStart <= !pseudo;
        pseudoFrameStart <= pseudo;
        t = cycles;
        @(posedge clk);
        frameStart <= 1'b0;
        pseudoFrameStart <= 1'b0;
    endtask
    task automatic capRead(output int v);
        logic [31:0] h, l;
        logic err;
        apb(1'b0, acu_pkg::OFF_CAPTURE_VALUE_HIGH, 32'h0, h, err);
        apb(1'b0, acu_pkg::OFF_CAPTURE_VALUE_LOW, 32'h0, l, err);
        v = int'({h[7:0], l[7:0]});
    endtask
    task automatic burst(input int n);
        @(posedge clk);
        burstLen <= 8'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2 * n + 8) @(posedge clk);
    endtask
    initial begin
        logic [31:0] rd, rst [7];
        logic [31:0] v [7];
        logic [31:0] expQ [$];
        logic err;
        int a, b, k, t0, t1, mN;
        int dl [4];
        rst = '{32'(acu_pkg::FREQ_RESET[23:16]), 32'(acu_pkg::FREQ_RESET[15:8]),
            32'(acu_pkg::FREQ_RESET[7:0]), 32'h0, 32'h0, 32'(acu_pkg::DIV_SEL_RESET), 32'h0};
        dl = '{1, 2, 6, 15};
        void'($urandom(71904));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk(8'(4 * i), rst[i]);
        apb(1'b1, 8'h1c, $urandom, rd, err);
        chk(32'(err), 32'h1);
        wr(acu_pkg::OFF_CAPTURE_VALUE_LOW, $urandom);
        rdchk(acu_pkg::OFF_CAPTURE_VALUE_LOW, 32'h0);
        // register model: staged bytes, active low byte, masked control fields
        for (int i = 0; i < 7; i++) begin
            v[i] = $urandom;
            wr(8'(4 * i), v[i]);
        end
        expQ.push_back(v[0] & 32'hff);
        expQ.push_back(v[1] & 32'hff);
        expQ.push_back(v[2] & 32'hff);
        expQ.push_back(32'h0);
        expQ.push_back(32'h0);
        expQ.push_back(v[5] & 32'hf);
        expQ.push_back(v[6] & 32'h3);
        for (int i = 0; i < 7; i++) rdchk(8'(4 * i), expQ.pop_front());
        // a word below the lower limit must run as the limit itself
        wr(acu_pkg::OFF_FREQ_WORD_HIGH, 32'h0);
        wr(acu_pkg::OFF_FREQ_WORD_MID, 32'h0);
        wr(acu_pkg::OFF_FREQ_WORD_LOW_COMMIT, 32'h0);
        wr(acu_pkg::OFF_CLOCK_GEN_CONTROL, 32'h0);
        wr(acu_pkg::OFF_DIVIDER_CONTROL, 32'h0);
        measure(1);
        // staged bytes must not move the synthesizer before the low byte
        k = $urandom_range(0, 255);
        wr(acu_pkg::OFF_FREQ_WORD_HIGH, 32'hc0);
        wr(acu_pkg::OFF_FREQ_WORD_MID, 32'(k));
        rdchk(acu_pkg::OFF_FREQ_WORD_MID, 32'(k));
        measure(1);
        wr(acu_pkg::OFF_FREQ_WORD_MID, 32'h0);
        wr(acu_pkg::OFF_FREQ_WORD_LOW_COMMIT, 32'h0);
        mN = 48;
        measure(mN / 24);
        foreach (dl[i]) begin
            wr(acu_pkg::OFF_DIVIDER_CONTROL, 32'(dl[i]));
            rdchk(acu_pkg::OFF_DIVIDER_CONTROL, 32'(dl[i]));
            measure((dl[i] + 1) * mN / 24);
        end
        wr(acu_pkg::OFF_FREQ_WORD_HIGH, 32'h60);
        wr(acu_pkg::OFF_FREQ_WORD_LOW_COMMIT, 32'h0);
        wr(acu_pkg::OFF_DIVIDER_CONTROL, 32'h1);
        wr(acu_pkg::OFF_CLOCK_GEN_CONTROL, 32'h1);
        pulse(1'b0, t0);
        capRead(a);
        k = $urandom_range(1, 40);
        burst(k);
        pulse(1'b1, t1);
        capRead(b);
        chk(32'((b - a) & 16'hffff), 32'(k));
        burst(5);
        capRead(a);
        chk(32'(a), 32'(b));
        wr(acu_pkg::OFF_CLOCK_GEN_CONTROL, 32'h0);
        pulse(1'b0, t0);
        capRead(a);
        repeat (400) @(posedge clk);
        pulse(1'b0, t1);
        capRead(b);
        k = (t1 - t0) / 4;
        chk(32'((b - a) >= k - 1 && (b - a) <= k + 1), 32'h1);
        // firmware nudge by one step while running
        wr(acu_pkg::OFF_FREQ_WORD_LOW_COMMIT, 32'h1);
        rdchk(acu_pkg::OFF_FREQ_WORD_LOW_COMMIT, 32'h1);
        wr(acu_pkg::OFF_CLOCK_GEN_CONTROL, 32'h2);
        repeat (20) @(posedge clk);
        summarize();
    end
endmodule
